// file: rtl/cmpc_map.svh
// Register map, field positions, reset values and codes of the
// comparator control block.
// Assumes a 32-bit AHB-Lite bus and a 100 MHz REF_CLK_I.
// Overview of operation
// R1 - Result bit is high while positive input exceeds negative input.
// R2 - Mux enabled and converter off: channel codes 0..10 feed negative input.
// R3 - Mux disabled or converter on: negative input is a dedicated pin.
// R4 - Pair select picks positive/negative dedicated pins per fixed table.
// R5 - Negative from mux: pair select picks only positive pin A, B or C.
// R6 - Bandgap select replaces positive pin by internal 1.1V reference.
// R7 - Raw comparator output is synchronised, one to two cycles late.
// R8 - Event flag sets on output transition matching the event mode.
// R9 - Flag clears on vector taken or by writing one to it.
// R10 - Interrupt requested only with flag, enable and global enable set.
// R11 - Mode 00 toggle, 10 falling, 11 rising, 01 reserved.
// R12 - Power off bit switches comparator off, writable any time.
// R13 - Software disables the interrupt before changing power or mode bits.
// R14 - Hysteresis select enables hysteresis, level bit picks 20mV or 50mV.
// R15 - Register A at index 0x08 holds control bits, all reset to zero.
// R16 - Register B at index 0x09 holds hysteresis bits and pair select.
// R17 - Converter enable set means converter on, owning its input mux.
// R18 - Edge detection compares synchronised result with previous cycle.
`ifndef CMPC_MAP_SVH
`define CMPC_MAP_SVH

// ----------------------------------------------------------------------
// Register indices and byte addresses
// ----------------------------------------------------------------------
`define CMPC_IDX_CSRA        8'h08
`define CMPC_IDX_CSRB        8'h09
`define CMPC_IDX_IRQ_STATUS  8'h0a
`define CMPC_IDX_IRQ_MASK    8'h0b
`define CMPC_ADDR_CSRA       8'h20
`define CMPC_ADDR_CSRB       8'h24
`define CMPC_ADDR_IRQ_STATUS 8'h28
`define CMPC_ADDR_IRQ_MASK   8'h2c

// ----------------------------------------------------------------------
// Register A fields
// ----------------------------------------------------------------------
`define CMPC_A_POWER_OFF  7
`define CMPC_A_BANDGAP    6
`define CMPC_A_RESULT     5
`define CMPC_A_FLAG       4
`define CMPC_A_IRQ_EN     3
`define CMPC_A_MUX_EN     2
`define CMPC_A_MODE_HI    1
`define CMPC_A_MODE_LO    0

// ----------------------------------------------------------------------
// Register B fields, status and mask fields
// ----------------------------------------------------------------------
`define CMPC_B_HYST_EN    7
`define CMPC_B_HYST_LVL   6
`define CMPC_B_PAIR_HI    2
`define CMPC_B_PAIR_LO    0
`define CMPC_IRQ_EVENT    0

// ----------------------------------------------------------------------
// Codes and reset values
// ----------------------------------------------------------------------
`define CMPC_MODE_TOGGLE  2'h0
`define CMPC_MODE_RSVD    2'h1
`define CMPC_MODE_FALL    2'h2
`define CMPC_MODE_RISE    2'h3
`define CMPC_CHAN_MAX     6'h0a
`define CMPC_RST_BITS     1'h0
`define CMPC_RST_PAIR     3'h0
`define CMPC_RST_MODE     2'h0
`define CMPC_RST_HREADY   1'h1

`endif

// file: rtl/cmpc_pkg.sv
// Types of the comparator control block.
// Constants live in cmpc_map.svh.
package cmpc_pkg;

  // Input selection codes driven to the analog mux
  typedef enum logic [1:0] {
    CMPC_PIN_A   = 2'h0,
    CMPC_PIN_B   = 2'h1,
    CMPC_PIN_C   = 2'h2,
    CMPC_PIN_ALT = 2'h3  // Bandgap (positive) or converter mux (negative)
  } cmpc_pin_t;

  // Synchroniser state
  typedef struct packed {
    logic meta;
    logic stable;
  } cmpc_sync_t;

  // Whole state of the top module
  typedef struct packed {
    logic        power_off;
    logic        bandgap;
    logic        flag;
    logic        irq_en;
    logic        mux_en;
    logic [1:0]  mode;
    logic        hyst_en;
    logic        hyst_lvl;
    logic [2:0]  pair;
    logic        res_prev;
    logic        dph_write;
    logic [7:0]  dph_addr;
    logic        hready;
    logic [31:0] hrdata;
    logic        irq;
    cmpc_pin_t   pos_sel;
    cmpc_pin_t   neg_sel;
    logic [3:0]  chan;
    logic        chan_valid;
  } cmpc_state_t;

endpackage

// file: rtl/cmpc_sync.sv
// Two-stage synchroniser for one asynchronous level.
// Assumes the input may change at any time relative to clk_i.
`timescale 1ns/1ps
module cmpc_sync (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  // Level in and out
  input  wire logic async_i,
  output logic      sync_o
);

  cmpc_pkg::cmpc_sync_t st_q;
  cmpc_pkg::cmpc_sync_t st_d;

  // Meta stage feeds only the stable stage
  always_comb
  begin
    st_d.meta   = async_i;
    st_d.stable = st_q.meta;
    if (!rst_n_i)
    begin
      st_d = '0;
    end
  end

  // State register
  always_ff @(posedge clk_i)
  begin
    st_q <= st_d;
  end

  assign sync_o = st_q.stable;

endmodule

// file: rtl/cmpc_top.sv
// Digital control of the on-chip analog comparator: input selection,
// result synchronisation, event detection, interrupt and registers.
// Assumes one AHB-Lite master on REF_CLK_I, converter status from
// logic on the same clock, and an asynchronous raw comparator output.
// HSIZE is ignored: every access is treated as one whole word.
// Software must drop the enable before changing power or mode bits.
`timescale 1ns/1ps
`include "cmpc_map.svh"
module cmpc_top (
  // Clock and reset
  input  wire logic        REF_CLK_I,
  input  wire logic        RST_N_I,
  // AHB-Lite slave
  input  wire logic        HSEL_I,
  input  wire logic [31:0] HADDR_I,
  input  wire logic [1:0]  HTRANS_I,
  input  wire logic        HWRITE_I,
  input  wire logic [2:0]  HSIZE_I,
  input  wire logic [31:0] HWDATA_I,
  input  wire logic        HREADY_I,
  output logic             HREADYOUT_O,
  output logic             HRESP_O,
  output logic [31:0]      HRDATA_O,
  // Converter status and processor interrupt side
  input  wire logic        CONV_ENABLE_I,
  input  wire logic [5:0]  CONV_CHAN_I,
  input  wire logic        GLOBAL_IRQ_EN_I,
  input  wire logic        IRQ_TAKEN_I,
  output logic             IRQ_O,
  // Analog comparator
  input  wire logic        CMP_RAW_I,
  output logic             CMP_POWER_OFF_O,
  output logic [1:0]       POS_SEL_O,
  output logic [1:0]       NEG_SEL_O,
  output logic [3:0]       NEG_CHAN_O,
  output logic             NEG_CHAN_VALID_O,
  output logic             HYST_EN_O,
  output logic             HYST_LEVEL_O
);

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  cmpc_pkg::cmpc_state_t st_q;
  cmpc_pkg::cmpc_state_t st_d;
  logic                  result;
  logic                  addr_take;
  logic                  wr_csra;
  logic                  wr_csrb;
  logic                  wr_stat;
  logic                  wr_mask;
  logic                  rise;
  logic                  fall;
  logic                  event_hit;
  logic                  neg_from_mux;
  logic                  mux_en_nx;
  logic [7:0]            csra_view;
  logic [7:0]            csrb_view;
  logic [7:0]            rd_addr;
  logic [31:0]           rd_word;

  // ----------------------------------------------------------------------
  // Result synchroniser
  // ----------------------------------------------------------------------
  // Raw output is asynchronous to the bus clock
  // Two flops cost a cycle of latency but keep metastability out
  cmpc_sync u_sync (
    .clk_i   (REF_CLK_I),
    .rst_n_i (RST_N_I),
    .async_i (CMP_RAW_I),
    .sync_o  (result)
  ); // R7 R1

  // ----------------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------------
  // Only NONSEQ/SEQ with the bus ready open a transfer
  // Only the low address byte is decoded, so upper bits alias
  assign addr_take = HSEL_I & HTRANS_I[1] & HREADY_I;
  assign rd_addr   = HADDR_I[7:0];

  // Write strobes act in the data phase of a taken write
  // Strobes use the captured address, not the live bus
  always_comb
  begin
    wr_csra = 1'b0;
    wr_csrb = 1'b0;
    wr_stat = 1'b0;
    wr_mask = 1'b0;
    if (st_q.dph_write && st_q.dph_addr == `CMPC_ADDR_CSRA)
    begin
      wr_csra = 1'b1;
    end
    else if (st_q.dph_write && st_q.dph_addr == `CMPC_ADDR_CSRB)
    begin
      wr_csrb = 1'b1;
    end
    else if (st_q.dph_write && st_q.dph_addr == `CMPC_ADDR_IRQ_STATUS)
    begin
      wr_stat = 1'b1;
    end
    else if (st_q.dph_write && st_q.dph_addr == `CMPC_ADDR_IRQ_MASK)
    begin
      wr_mask = 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Event detection
  // ----------------------------------------------------------------------
  // Edges from the synchronised result against its last value
  // Using the synchronised copy keeps metastable samples from faking edges
  assign rise = result & ~st_q.res_prev; // R18
  assign fall = ~result & st_q.res_prev; // R18

  // Reserved mode never fires, so a stray code cannot interrupt
  always_comb
  begin
    case (st_q.mode)
      `CMPC_MODE_TOGGLE: event_hit = rise | fall; // R11 R8
      `CMPC_MODE_FALL:   event_hit = fall; // R11 R8
      `CMPC_MODE_RISE:   event_hit = rise; // R11 R8
      default:           event_hit = 1'b0; // R11
    endcase
  end

  // Next mux enable, so routing follows a write at the edge it lands
  always_comb
  begin
    mux_en_nx = st_q.mux_en;
    if (wr_csra)
    begin
      mux_en_nx = HWDATA_I[`CMPC_A_MUX_EN];
    end
    if (!RST_N_I)
    begin
      mux_en_nx = `CMPC_RST_BITS;
    end
  end

  // Converter owns its mux while it is on
  assign neg_from_mux = mux_en_nx & ~CONV_ENABLE_I; // R2 R3 R17

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb
  begin
    st_d = st_q;

    // Result history for edge detection
    st_d.res_prev = result;

    // Register A writes; the result bit is read-only
    if (wr_csra)
    begin
      st_d.power_off = HWDATA_I[`CMPC_A_POWER_OFF]; // R12
      st_d.bandgap   = HWDATA_I[`CMPC_A_BANDGAP];
      st_d.irq_en    = HWDATA_I[`CMPC_A_IRQ_EN];
      st_d.mux_en    = HWDATA_I[`CMPC_A_MUX_EN];
      st_d.mode      = HWDATA_I[`CMPC_A_MODE_HI:`CMPC_A_MODE_LO];
    end

    // Register B writes; bits 5..3 are read-only
    if (wr_csrb)
    begin
      st_d.hyst_en  = HWDATA_I[`CMPC_B_HYST_EN];
      st_d.hyst_lvl = HWDATA_I[`CMPC_B_HYST_LVL];
      st_d.pair     = HWDATA_I[`CMPC_B_PAIR_HI:`CMPC_B_PAIR_LO];
    end

    // Mask register shares its bit with the enable in register A
    if (wr_mask)
    begin
      st_d.irq_en = HWDATA_I[`CMPC_IRQ_EVENT];
    end

    // Flag clears: vector taken, or one written through A or status
    if (IRQ_TAKEN_I) // R9
    begin
      st_d.flag = 1'b0;
    end
    if (wr_csra && HWDATA_I[`CMPC_A_FLAG]) // R9
    begin
      st_d.flag = 1'b0;
    end
    if (wr_stat && HWDATA_I[`CMPC_IRQ_EVENT]) // R9
    begin
      st_d.flag = 1'b0;
    end

    // A new event beats a clear in the same cycle
    if (event_hit)
    begin
      st_d.flag = 1'b1; // R8
    end

    // Interrupt line follows the next-state flag and enable
    st_d.irq = st_d.flag & st_d.irq_en & GLOBAL_IRQ_EN_I; // R10

    // Registered selections keep glitches off the analog mux
    // Positive input selection
    if (st_d.bandgap)
    begin
      st_d.pos_sel = cmpc_pkg::CMPC_PIN_ALT; // R6
    end
    else if (neg_from_mux)
    begin
      if (st_d.pair[2])
      begin
        st_d.pos_sel = cmpc_pkg::CMPC_PIN_C; // R5
      end
      else if (st_d.pair[1])
      begin
        st_d.pos_sel = cmpc_pkg::CMPC_PIN_B; // R5
      end
      else
      begin
        st_d.pos_sel = cmpc_pkg::CMPC_PIN_A; // R5
      end
    end
    else
    begin
      case (st_d.pair)
        3'h0, 3'h1: st_d.pos_sel = cmpc_pkg::CMPC_PIN_A; // R4
        3'h2, 3'h3: st_d.pos_sel = cmpc_pkg::CMPC_PIN_B; // R4
        default:    st_d.pos_sel = cmpc_pkg::CMPC_PIN_C; // R4
      endcase
    end

    // Negative input selection
    if (neg_from_mux)
    begin
      st_d.neg_sel    = cmpc_pkg::CMPC_PIN_ALT; // R2
      st_d.chan       = CONV_CHAN_I[3:0]; // R2
      st_d.chan_valid = (CONV_CHAN_I <= `CMPC_CHAN_MAX); // R2
    end
    else
    begin
      st_d.chan_valid = 1'b0; // R3
      st_d.chan       = 4'h0;
      case (st_d.pair)
        3'h0:       st_d.neg_sel = cmpc_pkg::CMPC_PIN_B; // R4 R3
        3'h1, 3'h3: st_d.neg_sel = cmpc_pkg::CMPC_PIN_C; // R4 R3
        3'h2, 3'h4: st_d.neg_sel = cmpc_pkg::CMPC_PIN_A; // R4 R3
        default:    st_d.neg_sel = cmpc_pkg::CMPC_PIN_B; // R4 R3
      endcase
    end

    // Address phase capture; zero wait states always
    st_d.dph_write = addr_take & HWRITE_I;
    st_d.dph_addr  = addr_take ? rd_addr : 8'h00;
    st_d.hready    = `CMPC_RST_HREADY;

    // Read data from next state, so a write just before is seen
    // Zero outside a read data phase keeps stale data off the bus
    st_d.hrdata = (addr_take && !HWRITE_I) ? rd_word : 32'h0000_0000;

    // Synchronous reset to documented values
    if (!RST_N_I)
    begin
      st_d            = '0; // R15
      st_d.power_off  = `CMPC_RST_BITS; // R15
      st_d.mode       = `CMPC_RST_MODE; // R15
      st_d.pair       = `CMPC_RST_PAIR; // R16
      st_d.hready     = `CMPC_RST_HREADY;
      st_d.pos_sel    = cmpc_pkg::CMPC_PIN_A;
      st_d.neg_sel    = cmpc_pkg::CMPC_PIN_B;
    end
  end

  // ----------------------------------------------------------------------
  // Read views
  // ----------------------------------------------------------------------
  // Register A view, result taken live from the synchroniser
  always_comb
  begin
    csra_view                                   = 8'h00;
    csra_view[`CMPC_A_POWER_OFF]                = st_d.power_off;
    csra_view[`CMPC_A_BANDGAP]                  = st_d.bandgap;
    csra_view[`CMPC_A_RESULT]                   = result; // R7
    csra_view[`CMPC_A_FLAG]                     = st_d.flag;
    csra_view[`CMPC_A_IRQ_EN]                   = st_d.irq_en;
    csra_view[`CMPC_A_MUX_EN]                   = st_d.mux_en;
    csra_view[`CMPC_A_MODE_HI:`CMPC_A_MODE_LO]  = st_d.mode; // R15
  end

  // Register B view, reserved bits read zero
  always_comb
  begin
    csrb_view                                   = 8'h00;
    csrb_view[`CMPC_B_HYST_EN]                  = st_d.hyst_en;
    csrb_view[`CMPC_B_HYST_LVL]                 = st_d.hyst_lvl;
    csrb_view[`CMPC_B_PAIR_HI:`CMPC_B_PAIR_LO]  = st_d.pair; // R16
  end

  // Address decode for reads; unmapped reads return zero
  // Aliases read the same bits as the register their low address byte selects
  always_comb
  begin
    rd_word = 32'h0000_0000;
    if (rd_addr == `CMPC_ADDR_CSRA)
    begin
      rd_word = {24'h00_0000, csra_view};
    end
    else if (rd_addr == `CMPC_ADDR_CSRB)
    begin
      rd_word = {24'h00_0000, csrb_view};
    end
    else if (rd_addr == `CMPC_ADDR_IRQ_STATUS)
    begin
      rd_word = {31'h0000_0000, st_d.flag};
    end
    else if (rd_addr == `CMPC_ADDR_IRQ_MASK)
    begin
      rd_word = {31'h0000_0000, st_d.irq_en};
    end
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  // One register for all state; reset lives in the next-state logic
  always_ff @(posedge REF_CLK_I)
  begin
    st_q <= st_d;
  end

  // ----------------------------------------------------------------------
  // Outputs, each straight from a flop except HRESP_O, tied low
  // ----------------------------------------------------------------------
  assign HREADYOUT_O      = st_q.hready;
  // No error case exists, so the response is always OKAY
  assign HRESP_O          = 1'b0 & st_q.hready;
  assign HRDATA_O         = st_q.hrdata;
  assign IRQ_O            = st_q.irq; // R10
  assign CMP_POWER_OFF_O  = st_q.power_off; // R12
  assign POS_SEL_O        = st_q.pos_sel;
  assign NEG_SEL_O        = st_q.neg_sel;
  assign NEG_CHAN_O       = st_q.chan;
  assign NEG_CHAN_VALID_O = st_q.chan_valid;
  assign HYST_EN_O        = st_q.hyst_en; // R14
  assign HYST_LEVEL_O     = st_q.hyst_lvl; // R14

endmodule

// file: verif/cmpc_properties.sv
// Port-level checks of the comparator control block.
// Assumes a bind to cmpc_top and single-word AHB-Lite transfers.
`timescale 1ns/1ps
module cmpc_properties (
  // Clock, reset and bus
  input  wire logic        REF_CLK_I,
  input  wire logic        RST_N_I,
  input  wire logic        HSEL_I,
  input  wire logic [31:0] HADDR_I,
  input  wire logic [1:0]  HTRANS_I,
  input  wire logic        HWRITE_I,
  input  wire logic        HREADY_I,
  input  wire logic        HREADYOUT_O,
  input  wire logic        HRESP_O,
  input  wire logic [31:0] HRDATA_O,
  // Converter and interrupt side
  input  wire logic        CONV_ENABLE_I,
  input  wire logic        GLOBAL_IRQ_EN_I,
  input  wire logic        IRQ_TAKEN_I,
  input  wire logic        IRQ_O,
  // Analog side
  input  wire logic        CMP_POWER_OFF_O,
  input  wire logic [1:0]  POS_SEL_O,
  input  wire logic [1:0]  NEG_SEL_O,
  input  wire logic [3:0]  NEG_CHAN_O,
  input  wire logic        NEG_CHAN_VALID_O,
  input  wire logic        HYST_EN_O,
  input  wire logic        HYST_LEVEL_O
);
  default clocking cb @(posedge REF_CLK_I);
  endclocking
  default disable iff (!RST_N_I);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Write data phase marker, so config changes can be traced to a write
  logic take;
  logic wr_q;
  logic conv_q;
  assign take = HSEL_I && HTRANS_I[1] && HREADY_I;
  // Converter switching also moves the routing, with no write
  always_ff @(posedge REF_CLK_I)
  begin
    conv_q <= CONV_ENABLE_I;
    if (!RST_N_I)
      wr_q <= 1'b0;
    else
      wr_q <= take && HWRITE_I;
  end

  sequence s_read_b;
    take && !HWRITE_I && HADDR_I[7:0] == 8'h24;
  endsequence
  sequence s_data_phase;
    s_read_b ##1 1'b1;
  endsequence

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_bus_okay: assert property (HREADYOUT_O && !HRESP_O)
    else $error("bus not ready or error response");
  a_rdata_idle: assert property (HRDATA_O != 32'h0 |-> $past(take && !HWRITE_I))
    else $error("read data outside a read data phase");
  a_reserved_b: assert property (s_data_phase |-> HRDATA_O[31:8] == 24'h0 && HRDATA_O[5:3] == 3'h0)
    else $error("reserved bits of register B not zero");
  a_conv_owns: assert property ($past(CONV_ENABLE_I) |-> NEG_SEL_O != 2'h3)
    else $error("converter mux routed while converter on");
  a_chan_idle: assert property (NEG_SEL_O != 2'h3 |-> NEG_CHAN_O == 4'h0 && !NEG_CHAN_VALID_O)
    else $error("channel shown without mux routing");
  a_chan_range: assert property (NEG_CHAN_VALID_O |-> NEG_SEL_O == 2'h3 && NEG_CHAN_O <= 4'ha)
    else $error("channel valid out of range");
  a_irq_gie: assert property (IRQ_O |-> $past(GLOBAL_IRQ_EN_I))
    else $error("interrupt without global enable");
  a_irq_drop: assert property ($fell(IRQ_O) |-> $past(!GLOBAL_IRQ_EN_I || IRQ_TAKEN_I || wr_q))
    else $error("interrupt dropped without cause");
  a_cfg_write: assert property ($changed({CMP_POWER_OFF_O, HYST_EN_O, HYST_LEVEL_O, POS_SEL_O})
    |-> $past(wr_q || CONV_ENABLE_I != conv_q))
    else $error("config output changed without a write");
endmodule

bind cmpc_top cmpc_properties cmpc_properties_inst (
  .REF_CLK_I(REF_CLK_I), .RST_N_I(RST_N_I), .HSEL_I(HSEL_I), .HADDR_I(HADDR_I),
  .HTRANS_I(HTRANS_I), .HWRITE_I(HWRITE_I), .HREADY_I(HREADY_I), .HREADYOUT_O(HREADYOUT_O),
  .HRESP_O(HRESP_O), .HRDATA_O(HRDATA_O), .CONV_ENABLE_I(CONV_ENABLE_I),
  .GLOBAL_IRQ_EN_I(GLOBAL_IRQ_EN_I), .IRQ_TAKEN_I(IRQ_TAKEN_I), .IRQ_O(IRQ_O),
  .CMP_POWER_OFF_O(CMP_POWER_OFF_O), .POS_SEL_O(POS_SEL_O), .NEG_SEL_O(NEG_SEL_O),
  .NEG_CHAN_O(NEG_CHAN_O), .NEG_CHAN_VALID_O(NEG_CHAN_VALID_O), .HYST_EN_O(HYST_EN_O),
  .HYST_LEVEL_O(HYST_LEVEL_O));

// file: verif/cmpc_top_tb.sv
// Self-checking bench of the comparator control block.
// Assumes cmpc_top alone on one AHB-Lite master; HSIZE tied to word.
`timescale 1ns/1ps
`include "cmpc_map.svh"
module cmpc_top_tb;
  typedef struct packed {
    logic [7:0] a;
    logic [7:0] b;
    logic       cv;
    logic [5:0] ch;
    logic [1:0] ps;
    logic [1:0] ns;
    logic [3:0] nc;
    logic       v;
  } cmpc_row_t;

  logic        clk, rst_n, hsel, hwrite, rdy, resp, conv, gie, taken, raw, irq;
  logic        pwr, hen, hlv, vld, rdy_s;
  logic [31:0] haddr, hwdata, hrdata, rd_s, v;
  logic [1:0]  htrans, pos, neg;
  logic [5:0]  chan;
  logic [3:0]  nch;
  logic [1:0]  md [4] = '{2'h0, 2'h2, 2'h3, 2'h1};
  int          mismatches, n_checks;
  // Selection table: register values beside the routing they give
  cmpc_row_t   rows [14] = '{
    '{8'h00, 8'h00, 1'b0, 6'h00, 2'h0, 2'h1, 4'h0, 1'b0},
    '{8'h00, 8'h01, 1'b0, 6'h00, 2'h0, 2'h2, 4'h0, 1'b0},
    '{8'h00, 8'h02, 1'b0, 6'h00, 2'h1, 2'h0, 4'h0, 1'b0},
    '{8'h00, 8'h03, 1'b0, 6'h00, 2'h1, 2'h2, 4'h0, 1'b0},
    '{8'h00, 8'h04, 1'b0, 6'h00, 2'h2, 2'h0, 4'h0, 1'b0},
    '{8'h80, 8'hc5, 1'b0, 6'h00, 2'h2, 2'h1, 4'h0, 1'b0},
    '{8'h00, 8'h86, 1'b0, 6'h00, 2'h2, 2'h1, 4'h0, 1'b0},
    '{8'h40, 8'h07, 1'b0, 6'h00, 2'h3, 2'h1, 4'h0, 1'b0},
    '{8'h04, 8'h00, 1'b0, 6'h00, 2'h0, 2'h3, 4'h0, 1'b1},
    '{8'h04, 8'h02, 1'b0, 6'h0a, 2'h1, 2'h3, 4'ha, 1'b1},
    '{8'h04, 8'h05, 1'b0, 6'h09, 2'h2, 2'h3, 4'h9, 1'b1},
    '{8'h04, 8'h03, 1'b0, 6'h0b, 2'h1, 2'h3, 4'hb, 1'b0},
    '{8'h04, 8'h00, 1'b1, 6'h05, 2'h0, 2'h1, 4'h0, 1'b0},
    '{8'h44, 8'h04, 1'b0, 6'h03, 2'h3, 2'h3, 4'h3, 1'b1}};

  cmpc_top cmpc_top_inst (
    .REF_CLK_I(clk), .RST_N_I(rst_n), .HSEL_I(hsel), .HADDR_I(haddr), .HTRANS_I(htrans),
    .HWRITE_I(hwrite), .HSIZE_I(3'h2), .HWDATA_I(hwdata), .HREADY_I(rdy), .HREADYOUT_O(rdy),
    .HRESP_O(resp), .HRDATA_O(hrdata), .CONV_ENABLE_I(conv), .CONV_CHAN_I(chan),
    .GLOBAL_IRQ_EN_I(gie), .IRQ_TAKEN_I(taken), .IRQ_O(irq), .CMP_RAW_I(raw),
    .CMP_POWER_OFF_O(pwr), .POS_SEL_O(pos), .NEG_SEL_O(neg), .NEG_CHAN_O(nch),
    .NEG_CHAN_VALID_O(vld), .HYST_EN_O(hen), .HYST_LEVEL_O(hlv));

  // ----------------------------------------------------------------
  // Clock, edge samples and tasks
  // ----------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Outputs move only at rising edges, so the falling-edge copy is the edge value
  always @(negedge clk)
  begin
    rdy_s = rdy;
    rd_s = hrdata;
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e)
    begin
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
      mismatches++;
    end
  endtask
  task automatic wait_rdy;
    @(posedge clk);
    while (rdy_s !== 1'b1)
    begin
      @(posedge clk);
    end
  endtask
  // One single transfer; entered and left on a rising edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    wait_rdy;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy;
    v = rd_s;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(v, e);
  endtask
  task automatic do_reset;
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  // Watchdog, far beyond the few hundred cycles the tests need
  initial
  begin
    #200000;
    mismatches++;
    wrap_up;
  end
  initial
  begin
    {rst_n, hsel, hwrite, conv, gie, taken, raw, htrans, chan} = '0;
    {haddr, hwdata, mismatches, n_checks} = '0;
    do_reset;
    rdc(`CMPC_ADDR_CSRA, 32'h0);
    rdc(`CMPC_ADDR_CSRB, 32'h0);
    rdc(`CMPC_ADDR_IRQ_MASK, 32'h0);
    #1 chk({pos, neg}, {2'h0, 2'h1});
    chk({rdy, resp}, 32'h2);
    @(posedge clk);
    xfer(1'b1, 8'h30, 32'hff);
    rdc(8'h30, 32'h0);
    for (int i = 0; i < 14; i++)
    begin
      conv <= rows[i].cv;
      chan <= rows[i].ch;
      xfer(1'b1, `CMPC_ADDR_CSRA, {24'h0, rows[i].a});
      xfer(1'b1, `CMPC_ADDR_CSRB, {24'h0, rows[i].b});
      #1;
      chk({pos, neg, nch, vld}, {rows[i].ps, rows[i].ns, rows[i].nc, rows[i].v});
      chk({pwr, hen, hlv}, {rows[i].a[7], rows[i].b[7], rows[i].b[6]});
      @(posedge clk);
      rdc(`CMPC_ADDR_CSRA, {24'h0, rows[i].a});
      rdc(`CMPC_ADDR_CSRB, {24'h0, rows[i].b & 8'hc7});
    end
    // Every event mode, rising then falling; reserved code must stay quiet
    for (int m = 0; m < 4; m++)
    begin
      xfer(1'b1, `CMPC_ADDR_CSRA, {28'h1, 2'h0, md[m]});
      raw <= 1'b1;
      repeat (4) @(posedge clk);
      rdc(`CMPC_ADDR_CSRA, {26'h0, 1'b1, md[m] == 2'h0 || md[m] == 2'h3, 2'h0, md[m]});
      xfer(1'b1, `CMPC_ADDR_CSRA, {28'h1, 2'h0, md[m]});
      raw <= 1'b0;
      repeat (4) @(posedge clk);
      rdc(`CMPC_ADDR_CSRA, {27'h0, md[m] == 2'h0 || md[m] == 2'h2, 2'h0, md[m]});
    end
    // Exact event latency, then the request dropped by global enable, vector taken, status and mask writes
    gie <= 1'b1;
    xfer(1'b1, `CMPC_ADDR_CSRA, 32'h13);
    xfer(1'b1, `CMPC_ADDR_CSRA, 32'h1b);
    raw <= 1'b1;
    repeat (2) @(posedge clk);
    #1 chk(irq, 1'b0);
    @(posedge clk);
    #1 chk(irq, 1'b1);
    @(posedge clk);
    gie <= 1'b0;
    @(posedge clk);
    #1 chk(irq, 1'b0);
    gie <= 1'b1;
    @(posedge clk);
    taken <= 1'b1;
    @(posedge clk);
    taken <= 1'b0;
    #1 chk(irq, 1'b0);
    @(posedge clk);
    rdc(`CMPC_ADDR_CSRA, 32'h2b);
    for (int j = 0; j < 2; j++)
    begin
      raw <= 1'b0;
      repeat (4) @(posedge clk);
      raw <= 1'b1;
      repeat (4) @(posedge clk);
      xfer(1'b1, j ? `CMPC_ADDR_IRQ_MASK : `CMPC_ADDR_IRQ_STATUS, j ? 32'h0 : 32'h1);
      #1 chk(irq, 1'b0);
      @(posedge clk);
    end
    rdc(`CMPC_ADDR_IRQ_STATUS, 32'h1);
    rdc(`CMPC_ADDR_CSRA, 32'h33);
    // Event and vector taken at one edge: the set wins
    raw <= 1'b0;
    xfer(1'b1, `CMPC_ADDR_IRQ_STATUS, 32'h1);
    raw <= 1'b1;
    repeat (2) @(posedge clk);
    taken <= 1'b1;
    @(posedge clk);
    taken <= 1'b0;
    rdc(`CMPC_ADDR_IRQ_STATUS, 32'h1);
    raw <= 1'b0;
    do_reset;
    rdc(`CMPC_ADDR_CSRA, 32'h0);
    rdc(`CMPC_ADDR_CSRB, 32'h0);
    wrap_up;
  end
endmodule
